// ### design/prf_pkg.sv
// package: constants for the position reader output formatter
package prf_pkg;
  // ------------------------------------------------------------
  // resolution codes
  // ------------------------------------------------------------
  localparam logic [1:0] RES_FINE = 2'h0;
  localparam logic [1:0] RES_MM = 2'h1;
  localparam logic [1:0] RES_COARSE = 2'h2;
  localparam logic [1:0] RES_POS_RESET = RES_MM;
  localparam logic [1:0] RES_VEL_RESET = RES_FINE;
  // ------------------------------------------------------------
  // status word bit positions (bit no. n sits at index n-1)
  // ------------------------------------------------------------
  localparam int ST_FAULT = 0;
  localparam int ST_NOPOS = 1;
  localparam int ST_WARN = 2;
  localparam int ST_MARKER = 3;
  localparam int ST_VALID = 4;
  // ------------------------------------------------------------
  // values
  // ------------------------------------------------------------
  localparam logic [31:0] VEL_UNKNOWN = 32'h0000ffff;
  localparam logic [15:0] ERR_TURNED = 16'h0001;
  localparam logic [15:0] ERR_AMBIG = 16'h0002;
  localparam logic [15:0] ERR_INTERNAL_MIN = 16'h03e9;
  localparam logic [31:0] X_MAX_MM = 32'h00989680;
  localparam logic [31:0] VEL_MAX_FINE = 32'h00003a98;
  localparam logic [7:0] SET_X_LEN = 8'h04;
  localparam logic [7:0] SET_XV_LEN = 8'h08;
  localparam logic [7:0] SET_FULL_LEN = 8'h12;
  localparam logic [1:0] SET_X = 2'h0;
  localparam logic [1:0] SET_XV = 2'h1;
  localparam logic [1:0] SET_FULL = 2'h2;
endpackage

// ### design/prf_formatter.sv
// module: formats cyclic input data of a code-tape position reader
module prf_formatter
  import prf_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic sample_in,
  input wire logic signed [31:0] x_fine_in,
  input wire logic signed [31:0] y_fine_in,
  input wire logic [31:0] vel_in,
  input wire logic vel_known_in,
  input wire logic pos_found_in,
  input wire logic turned_in,
  input wire logic ambiguous_in,
  input wire logic internal_fault_in,
  input wire logic [15:0] internal_code_in,
  input wire logic [15:0] warnings_in,
  input wire logic marker_seen_in,
  input wire logic [15:0] marker_num_in,
  input wire logic [1:0] pos_res_in,
  input wire logic [1:0] vel_res_in,
  input wire logic [1:0] set_sel_in,
  input wire logic [4:0] byte_idx_in,
  output logic [31:0] x_coord_bits_out,
  output logic [31:0] y_coord_bits_out,
  output logic [31:0] velocity_bits_out,
  output logic [15:0] status_out,
  output logic [15:0] warn_bits_out,
  output logic [15:0] marker_num_out,
  output logic [7:0] set_len_out,
  output logic [7:0] byte_out,
  output logic frame_valid_out
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0] x;
    logic [31:0] y;
    logic [31:0] vel;
    logic [15:0] status;
    logic [15:0] warn;
    logic [15:0] marker;
    logic [1:0] pos_res;
    logic [1:0] vel_res;
    logic [7:0] obyte;
    logic [7:0] len;
    logic valid;
  } prf_state_t;

  prf_state_t st;
  prf_state_t next_st;

  // divide by 10 or 100; signed values are truncated toward zero
  function automatic logic [31:0] prf_scale(input logic [31:0] v, input logic [1:0] res);
    logic signed [31:0] s;
    s = v;
    unique case (res)
      RES_FINE: prf_scale = v;
      RES_COARSE: prf_scale = 32'(s / 32'sd100);
      default: prf_scale = 32'(s / 32'sd10);
    endcase
  endfunction

  // one byte of a field, low byte first
  function automatic logic [7:0] prf_lane(input logic [31:0] v, input logic [1:0] k);
    prf_lane = v[8*k +: 8];
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic fault;
  logic [15:0] err_code;
  logic [31:0] vel_raw;
  logic [31:0] vel_scaled;

  always_comb begin
    fault = internal_fault_in | turned_in | ambiguous_in;
    // priority: internal, then turned, then ambiguous
    if (internal_fault_in) begin
      err_code = internal_code_in;
    end else if (turned_in) begin
      err_code = ERR_TURNED;
    end else begin
      err_code = ERR_AMBIG;
    end
    // vel_in counts mm/s; code 0 is the coarsest 0.1 m/s step, so it divides most
    unique case (st.vel_res)
      RES_FINE: vel_scaled = vel_in / 32'd100;
      RES_COARSE: vel_scaled = vel_in;
      default: vel_scaled = vel_in / 32'd10;
    endcase
    vel_raw = vel_known_in ? vel_scaled : VEL_UNKNOWN;
    next_st = st;
    next_st.pos_res = pos_res_in;
    next_st.vel_res = vel_res_in;
    next_st.len = (set_sel_in == SET_X) ? SET_X_LEN :
                  (set_sel_in == SET_XV) ? SET_XV_LEN : SET_FULL_LEN;
    // whole frame latched on one strobe so no field mixes samples
    if (sample_in) begin
      next_st.valid = 1'b1;
      next_st.status = 16'h0000;
      next_st.status[ST_FAULT] = fault;
      next_st.status[ST_NOPOS] = ~pos_found_in;
      next_st.status[ST_WARN] = |warnings_in;
      next_st.status[ST_MARKER] = marker_seen_in;
      next_st.status[ST_VALID] = pos_found_in & ~fault;
      next_st.warn = warnings_in;
      next_st.marker = marker_num_in;
      if (!pos_found_in) begin
        next_st.x = 32'h0;
        next_st.y = 32'h0;
        next_st.vel = 32'h0;
      end else begin
        // 32 bits hold ten million mm at 1 and 10 mm
        next_st.x = prf_scale(x_fine_in, st.pos_res);
        next_st.y = prf_scale(y_fine_in, st.pos_res);
        next_st.vel = vel_raw;
      end
      if (fault) begin
        next_st.x = {16'h0000, err_code};
      end
    end
    // byte stream: status, x, y, vel, warn, marker in full set
    unique case (st.len)
      SET_FULL_LEN: begin
        if (byte_idx_in < 5'd2) begin
          next_st.obyte = byte_idx_in[0] ? st.status[15:8] : st.status[7:0];
        end else if (byte_idx_in < 5'd6) begin
          next_st.obyte = prf_lane(st.x, 2'(byte_idx_in - 5'd2));
        end else if (byte_idx_in < 5'd10) begin
          next_st.obyte = prf_lane(st.y, 2'(byte_idx_in - 5'd6));
        end else if (byte_idx_in < 5'd14) begin
          next_st.obyte = prf_lane(st.vel, 2'(byte_idx_in - 5'd10));
        end else if (byte_idx_in < 5'd16) begin
          next_st.obyte = byte_idx_in[0] ? st.warn[15:8] : st.warn[7:0];
        end else if (byte_idx_in < 5'd18) begin
          next_st.obyte = byte_idx_in[0] ? st.marker[15:8] : st.marker[7:0];
        end else begin
          next_st.obyte = 8'h00;
        end
      end
      default: begin
        if (byte_idx_in < 5'd4) begin
          next_st.obyte = prf_lane(st.x, byte_idx_in[1:0]);
        end else if (byte_idx_in < 5'(st.len)) begin
          next_st.obyte = prf_lane(st.vel, byte_idx_in[1:0]);
        end else begin
          next_st.obyte = 8'h00;
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      st <= '0;
      st.pos_res <= RES_POS_RESET;
      st.vel_res <= RES_VEL_RESET;
      st.status[ST_NOPOS] <= 1'b1;
      st.len <= SET_FULL_LEN;
    end else begin
      st <= next_st;
    end
  end

  assign x_coord_bits_out = st.x;
  assign y_coord_bits_out = st.y;
  assign velocity_bits_out = st.vel;
  assign status_out = st.status;
  assign warn_bits_out = st.warn;
  assign marker_num_out = st.marker;
  assign set_len_out = st.len;
  assign byte_out = st.obyte;
  assign frame_valid_out = st.valid;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_fault_sample;
    sample_in && (internal_fault_in || turned_in || ambiguous_in);
  endsequence

  a_fault_code_x: assert property (s_fault_sample |=> status_out[0] && x_coord_bits_out[31:16] == 16'h0)
    else $error("fault frame without code in x");
  a_internal_wins: assert property (sample_in && internal_fault_in |=> x_coord_bits_out[15:0] == $past(internal_code_in))
    else $error("internal fault code not prioritised");
  a_turned_before_ambig: assert property (sample_in && !internal_fault_in && turned_in |=> x_coord_bits_out == 32'h1)
    else $error("turned code not prioritised");
  a_nopos_zero: assert property (sample_in && !pos_found_in |=> status_out[1] && y_coord_bits_out == 0 && velocity_bits_out == 0)
    else $error("no position frame not zeroed");
  a_vel_unknown: assert property (sample_in && pos_found_in && !vel_known_in |=> velocity_bits_out == 32'h0000ffff)
    else $error("unknown speed value wrong");
  a_status_upper: assert property (status_out[15:5] == 11'h0)
    else $error("upper status bits set");
  a_valid_flag: assert property (status_out[4] |-> !status_out[0] && !status_out[1])
    else $error("valid flag with fault or no position");
  a_warn_flag: assert property (sample_in |=> status_out[2] == (warn_bits_out != 16'h0) && warn_bits_out == $past(warnings_in))
    else $error("warning flag mismatch");
  a_hold_frame: assert property (!sample_in |=> $stable(x_coord_bits_out) && $stable(status_out))
    else $error("frame changed without sample");
  a_marker_num: assert property (sample_in |=> marker_num_out == $past(marker_num_in) && status_out[3] == $past(marker_seen_in))
    else $error("marker data mismatch");
endmodule

// ### tb/prf_reader_model.sv
// partner model: network controller reading one input set byte by byte
module prf_reader_model (
  input wire logic clk_in,
  input wire logic [7:0] byte_in,
  output logic [4:0] idx_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] frame [0:19];
  // ------------------------------------------------------------
  // reader
  // ------------------------------------------------------------
  // the answer lags the index by one edge, so one extra pass collects the last byte
  task automatic fetch(input int n);
    for (int i = 0; i <= n; i++) begin
      @(negedge clk_in);
      if (i > 0) frame[i-1] = byte_in;
      idx_out = 5'(i);
    end
  endtask
  initial idx_out = 5'h00;
endmodule

// ### tb/testbench.sv
// testbench: self-checking bench for the position reader output formatter
module testbench
  import prf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, resetn, smp, vk, pf, tu, am, inf, ms, fv;
  logic signed [31:0] xf, yf;
  logic [31:0] vel, xo, yo, vo;
  logic [15:0] icode, wbits, mnum, st, wo, mo;
  logic [1:0] pres, vres, ssel;
  logic [4:0] bidx;
  logic [7:0] slen, bo;
  int n_fail = 0;
  int cmp_count = 0;
  initial forever #2 clk = ~clk;
  prf_formatter i_prf_formatter (.ref_clk_in(clk), .resetn_in(resetn), .sample_in(smp),
    .x_fine_in(xf), .y_fine_in(yf), .vel_in(vel), .vel_known_in(vk), .pos_found_in(pf),
    .turned_in(tu), .ambiguous_in(am), .internal_fault_in(inf), .internal_code_in(icode),
    .warnings_in(wbits), .marker_seen_in(ms), .marker_num_in(mnum), .pos_res_in(pres),
    .vel_res_in(vres), .set_sel_in(ssel), .byte_idx_in(bidx), .x_coord_bits_out(xo),
    .y_coord_bits_out(yo), .velocity_bits_out(vo), .status_out(st), .warn_bits_out(wo),
    .marker_num_out(mo), .set_len_out(slen), .byte_out(bo), .frame_valid_out(fv));
  prf_reader_model u_reader (.clk_in(clk), .byte_in(bo), .idx_out(bidx));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // sample pulse lands on the next rising edge; fields are settled by the falling one
  // an idle cycle after each pulse keeps back-to-back calls from toggling smp in one step
  task automatic take();
    smp = 1'b1;
    @(negedge clk);
    smp = 1'b0;
    @(negedge clk);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_full();
    logic [143:0] pk;
    xf = -32'sd12345;
    yf = 32'sd5678;
    vel = 32'd4700;
    wbits = 16'h0005;
    ms = 1'b1;
    mnum = 16'h0123;
    take();
    pk = {16'h0123, 16'h0005, 32'h0000002f, 32'h00000237, 32'hfffffb2e, 16'h001c};
    chk("frame_valid", 32'(fv), 32'h1);
    u_reader.fetch(19);
    for (int i = 0; i < 18; i++) chk("byte", 32'(u_reader.frame[i]), 32'(pk[8*i +: 8]));
    chk("x", xo, 32'hfffffb2e);
    chk("status", 32'(st), 32'h001c);
    chk("warn", 32'(wo), 32'h0005);
    chk("marker", 32'(mo), 32'h0123);
    xf = 32'sd7;
    @(negedge clk);
    chk("x held", xo, 32'hfffffb2e);
    chk("past end", 32'(u_reader.frame[18]), 32'h0);
  endtask
  task automatic t_res();
    int d;
    for (int r = 0; r < 4; r++) begin
      d = (r == 0) ? 1 : (r == 2) ? 100 : 10;
      pres = 2'(r);
      vres = 2'(r);
      xf = 32'sd100000000;
      yf = -32'sd99;
      vel = 32'd12500;
      @(negedge clk);
      take();
      chk("x res", xo, 32'(100000000 / d));
      chk("y res", yo, 32'(-99 / d));
      chk("vel res", vo, 32'(12500 * d / 100));
    end
    pres = RES_MM;
    vres = RES_VEL_RESET;
    vk = 1'b0;
    take();
    chk("vel unknown", vo, VEL_UNKNOWN);
    chk("valid", 32'(st), 32'h001c);
    vk = 1'b1;
  endtask
  task automatic t_nopos();
    pf = 1'b0;
    wbits = 16'h0000;
    ms = 1'b0;
    take();
    chk("nopos x", xo, 32'h0);
    chk("nopos vel", vo, 32'h0);
    chk("nopos status", 32'(st), 32'h0002);
    chk("no warn", 32'(wo), 32'h0);
    pf = 1'b1;
  endtask
  task automatic t_fault();
    logic [2:0] src [3] = '{3'b101, 3'b110, 3'b010};
    logic [15:0] code [3] = '{16'h04d2, 16'h0001, 16'h0002};
    icode = 16'h04d2;
    for (int k = 0; k < 3; k++) begin
      {tu, am, inf} = src[k];
      take();
      chk("fault x", xo, {16'h0000, code[k]});
      chk("fault status", 32'(st), 32'h0001);
    end
    {tu, am, inf} = 3'b000;
  endtask
  task automatic t_sets();
    logic [7:0] len [4] = '{8'h04, 8'h08, 8'h12, 8'h12};
    // last fault frame: x holds code 2, speed 12.5 m/s at 0.1 m/s
    logic [63:0] xv = {32'h0000007d, 32'h00000002};
    for (int k = 0; k < 4; k++) begin
      ssel = 2'(k);
      @(negedge clk);
      chk("set len", 32'(slen), 32'(len[k]));
      u_reader.fetch(int'(len[k]) + 1);
      for (int i = 0; k < 2 && i < int'(len[k]); i++) begin
        chk("set byte", 32'(u_reader.frame[i]), 32'(xv[8*i +: 8]));
      end
      chk("beyond", 32'(u_reader.frame[len[k]]), 32'h0);
    end
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {smp, xf, yf, vel, tu, am, inf, icode, wbits, ms, mnum} = '0;
    vk = 1'b1;
    pf = 1'b1;
    pres = RES_MM;
    vres = RES_VEL_RESET;
    ssel = SET_FULL;
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    chk("reset status", 32'(st), 32'h0002);
    chk("reset len", 32'(slen), 32'h12);
    resetn = 1'b1;
    t_full();
    t_res();
    t_nopos();
    t_fault();
    t_sets();
    summarize();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    summarize();
  end
endmodule
